/* File: common/rpcs_pkg.sv */
// Constants and carrier types of the refresh and port chip select block.
package rpcs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_ADDR = 16'h2072;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // Register layout, bit 15 first.
  typedef struct packed {
    logic main_slow;
    logic video_slow;
    logic cas_first_refresh_enable;
    logic cas_first_self_refresh;
    logic scsi_decode_enable;
    logic [1:0] printer_port_decode;
    logic printer_port_bus_sel;
    logic [2:0] first_uart_decode;
    logic first_uart_bus_sel;
    logic [2:0] second_uart_decode;
    logic second_uart_bus_sel;
  } rpcs_cfg_t;

  typedef struct packed {
    logic scsi;
    logic printer;
    logic first_uart;
    logic second_uart;
  } rpcs_cs_t;

  // ----------------------------------------------------------------
  // Decode codes and address ranges
  // ----------------------------------------------------------------
  localparam logic [1:0] PAR_OFF = 2'h0;
  localparam logic [1:0] PAR_3BC = 2'h1;
  localparam logic [1:0] PAR_378 = 2'h2;
  localparam logic [1:0] PAR_278 = 2'h3;
  localparam logic [2:0] UART_OFF = 3'h0;
  localparam logic [2:0] UART_3F8 = 3'h1;
  localparam logic [2:0] UART_2F8 = 3'h2;
  localparam logic [2:0] UART_3E8 = 3'h3;
  localparam logic [2:0] UART_2E8 = 3'h4;
  // Address bits 15:4 of the SCSI window.
  localparam logic [11:0] SCSI_BASE = 12'h353;
  // Address bits 15:2 of the four byte printer window.
  localparam logic [13:0] PAR_BASE_3BC = 14'h00EF;
  // Address bits 15:3 of eight byte windows.
  localparam logic [12:0] PAR_BASE_378 = 13'h006F;
  localparam logic [12:0] PAR_BASE_278 = 13'h004F;
  localparam logic [12:0] UART_BASE_3F8 = 13'h007F;
  localparam logic [12:0] UART_BASE_2F8 = 13'h005F;
  localparam logic [12:0] UART_BASE_3E8 = 13'h007D;
  localparam logic [12:0] UART_BASE_2E8 = 13'h005D;

  // ----------------------------------------------------------------
  // Refresh timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int REFRESH_PERIOD_NS = 15600;
  localparam int REFRESH_CYC = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SLOW_FACTOR = 8;
  localparam logic [11:0] NORMAL_LIMIT = 12'(REFRESH_CYC - 1);
  localparam logic [11:0] SLOW_LIMIT = 12'(REFRESH_CYC * SLOW_FACTOR - 1);
  localparam logic [2:0] TICK_LAST = 3'(SLOW_FACTOR - 1);

  // True when the address lies in the window that a serial field selects.
  function automatic logic uart_hit(input logic [15:0] addr,
                                    input logic [2:0] code);
    logic [12:0] base;
    base = 13'h0000;
    case (code)
      UART_3F8: base = UART_BASE_3F8;
      UART_2F8: base = UART_BASE_2F8;
      UART_3E8: base = UART_BASE_3E8;
      UART_2E8: base = UART_BASE_2E8;
      default: base = 13'h0000;
    endcase
    return (code inside {UART_3F8, UART_2F8, UART_3E8, UART_2E8}) &&
           (addr[15:3] == base);
  endfunction : uart_hit

endpackage : rpcs_pkg

/* File: logic/rpcs_port_decode.sv */
// Combinational chip select decode for the SCSI, printer and serial ports.
`timescale 1ns/1ps
module rpcs_port_decode (
  // Address and configuration
  input wire logic [15:0] addr_i,
  input wire rpcs_pkg::rpcs_cfg_t cfg_i,
  // Decoded selects
  output rpcs_pkg::rpcs_cs_t hit_o
);

  always_comb begin
    hit_o = '0;
    hit_o.scsi = cfg_i.scsi_decode_enable &&
                 (addr_i[15:4] == rpcs_pkg::SCSI_BASE);
    if (cfg_i.printer_port_decode == rpcs_pkg::PAR_3BC) begin
      hit_o.printer = (addr_i[15:2] == rpcs_pkg::PAR_BASE_3BC);
    end else if (cfg_i.printer_port_decode == rpcs_pkg::PAR_378) begin
      hit_o.printer = (addr_i[15:3] == rpcs_pkg::PAR_BASE_378);
    end else if (cfg_i.printer_port_decode == rpcs_pkg::PAR_278) begin
      hit_o.printer = (addr_i[15:3] == rpcs_pkg::PAR_BASE_278);
    end else begin
      hit_o.printer = 1'b0;
    end
    hit_o.first_uart = rpcs_pkg::uart_hit(addr_i, cfg_i.first_uart_decode);
    hit_o.second_uart = rpcs_pkg::uart_hit(addr_i, cfg_i.second_uart_decode);
  end

endmodule : rpcs_port_decode

/* File: logic/rpcs_refresh_gen.sv */
// Refresh request generator with normal, slow and power down pacing.
`timescale 1ns/1ps
module rpcs_refresh_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic slow_i,
  input wire logic fpd_i,
  input wire logic tick_i,
  // Request
  output logic req_o
);

  typedef struct packed {
    logic [11:0] cnt;
    logic [2:0] ticks;
    logic req;
  } rpcs_ref_state_t;

  rpcs_ref_state_t q;
  rpcs_ref_state_t d;

  always_comb begin
    d = q;
    d.req = 1'b0;
    if (fpd_i) begin
      d.cnt = 12'h000;
      if (tick_i) begin
        if (!slow_i || q.ticks == rpcs_pkg::TICK_LAST) begin
          d.ticks = 3'h0;
          d.req = 1'b1;
        end else begin
          d.ticks = q.ticks + 3'h1;
        end
      end
    end else begin
      d.ticks = 3'h0;
      if (q.cnt >= (slow_i ? rpcs_pkg::SLOW_LIMIT : rpcs_pkg::NORMAL_LIMIT))
      begin
        d.cnt = 12'h000;
        d.req = 1'b1;
      end else begin
        d.cnt = q.cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign req_o = q.req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Gap and tick count since the last request, while the mode holds.
  logic [11:0] gap_q;
  logic [3:0] tick_seen_q;
  logic steady_q;
  logic mode_slow_q;
  logic mode_fpd_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_q <= 12'h000;
      tick_seen_q <= 4'h0;
      steady_q <= 1'b0;
      mode_slow_q <= 1'b0;
      mode_fpd_q <= 1'b0;
    end else begin
      mode_slow_q <= slow_i;
      mode_fpd_q <= fpd_i;
      gap_q <= q.req ? 12'h000 : gap_q + 12'h001;
      tick_seen_q <= q.req ? {3'h0, tick_i} : tick_seen_q + {3'h0, tick_i};
      if (q.req) begin
        steady_q <= 1'b1;
      end else if (slow_i != mode_slow_q || fpd_i != mode_fpd_q) begin
        steady_q <= 1'b0;
      end
    end
  end

  AST_PERIOD: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (d.req && steady_q && !fpd_i && slow_i == mode_slow_q)
      |-> gap_q + 12'h001 ==
        (slow_i ? rpcs_pkg::SLOW_LIMIT : rpcs_pkg::NORMAL_LIMIT))
    else $error("refresh gap wrong for selected rate");

  AST_EIGHTH_TICK: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (d.req && steady_q && fpd_i && slow_i && mode_fpd_q && mode_slow_q)
      |-> tick_seen_q == 4'h7)
    else $error("power down refresh not on eighth tick");

endmodule : rpcs_refresh_gen

/* File: logic/rpcs_top.sv */
// Refresh control and port chip select register with its decode logic.
`timescale 1ns/1ps

module rpcs_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // CPU I/O bus
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_data_i,
  output logic [15:0] io_data_o,
  output logic io_data_oe_o,
  // Power state and refresh tick
  input wire logic full_power_down_i,
  input wire logic suspend_i,
  input wire logic low_rate_refresh_tick_i,
  // DRAM refresh control
  output logic main_refresh_req_o,
  output logic video_refresh_req_o,
  output logic cas_first_refresh_enable_o,
  output logic cas_hold_low_o,
  // Port chip selects
  output logic cs_scsi_o,
  output logic cs_printer_o,
  output logic cs_first_uart_o,
  output logic cs_second_uart_o,
  // Port bus placement, 0 local peripheral bus, 1 expansion bus
  output logic printer_port_bus_sel_o,
  output logic first_uart_bus_sel_o,
  output logic second_uart_bus_sel_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr_s1;
    logic [15:0] addr_s2;
    logic [15:0] data_s1;
    logic [15:0] data_s2;
    logic wr_s1;
    logic wr_s2;
    logic wr_prev;
    logic rd_s1;
    logic rd_s2;
    logic tick_s1;
    logic tick_s2;
    logic tick_prev;
    logic fpd_s1;
    logic fpd_s2;
    logic susp_s1;
    logic susp_s2;
    rpcs_pkg::rpcs_cfg_t cfg;
    logic [15:0] rdata;
    logic rdata_oe;
    rpcs_pkg::rpcs_cs_t cs;
    logic cas_first;
    logic cas_hold;
  } rpcs_state_t;

  rpcs_state_t q;
  rpcs_state_t d;
  rpcs_pkg::rpcs_cs_t hit;
  logic wr_edge;
  logic reg_sel;
  logic tick_pulse;
  logic main_req;
  logic video_req;

  // Multi-bit address and data are taken two cycles after the pins; the
  // CPU holds them stable around its strobe, so skew between bits is
  // settled by the time the synced strobe edge is seen.
  assign reg_sel = (q.addr_s2 == rpcs_pkg::REG_ADDR);
  assign wr_edge = q.wr_s2 && !q.wr_prev;
  assign tick_pulse = q.tick_s2 && !q.tick_prev;

  rpcs_port_decode u_decode (
    .addr_i(q.addr_s2),
    .cfg_i(q.cfg),
    .hit_o(hit)
  );

  rpcs_refresh_gen u_main_refresh (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .slow_i(q.cfg.main_slow),
    .fpd_i(q.fpd_s2),
    .tick_i(tick_pulse),
    .req_o(main_req)
  );

  rpcs_refresh_gen u_video_refresh (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .slow_i(q.cfg.video_slow),
    .fpd_i(q.fpd_s2),
    .tick_i(tick_pulse),
    .req_o(video_req)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.addr_s1 = io_addr_i;
    d.addr_s2 = q.addr_s1;
    d.data_s1 = io_data_i;
    d.data_s2 = q.data_s1;
    d.wr_s1 = io_wr_i;
    d.wr_s2 = q.wr_s1;
    d.wr_prev = q.wr_s2;
    d.rd_s1 = io_rd_i;
    d.rd_s2 = q.rd_s1;
    d.tick_s1 = low_rate_refresh_tick_i;
    d.tick_s2 = q.tick_s1;
    d.tick_prev = q.tick_s2;
    d.fpd_s1 = full_power_down_i;
    d.fpd_s2 = q.fpd_s1;
    d.susp_s1 = suspend_i;
    d.susp_s2 = q.susp_s1;
    if (wr_edge && reg_sel) begin
      d.cfg = rpcs_pkg::rpcs_cfg_t'(q.data_s2);
    end
    d.rdata_oe = q.rd_s2 && reg_sel;
    d.rdata = (q.rd_s2 && reg_sel) ? 16'(q.cfg) : 16'h0000;
    d.cs = hit;
    d.cas_first = q.cfg.cas_first_refresh_enable;
    d.cas_hold = q.cfg.cas_first_self_refresh && q.susp_s2;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign io_data_o = q.rdata;
  assign io_data_oe_o = q.rdata_oe;
  assign main_refresh_req_o = main_req;
  assign video_refresh_req_o = video_req;
  assign cas_first_refresh_enable_o = q.cas_first;
  assign cas_hold_low_o = q.cas_hold;
  assign cs_scsi_o = q.cs.scsi;
  assign cs_printer_o = q.cs.printer;
  assign cs_first_uart_o = q.cs.first_uart;
  assign cs_second_uart_o = q.cs.second_uart;
  assign printer_port_bus_sel_o = q.cfg.printer_port_bus_sel;
  assign first_uart_bus_sel_o = q.cfg.first_uart_bus_sel;
  assign second_uart_bus_sel_o = q.cfg.second_uart_bus_sel;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_reg_write;
    wr_edge && reg_sel;
  endsequence

  sequence s_reg_read;
    q.rd_s2 && reg_sel;
  endsequence

  // Copy of the last written word, taken from the synced data and not from
  // the register, so that a write that fails to land shows up on a read.
  logic [15:0] wr_shadow_q;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_shadow_q <= rpcs_pkg::CFG_RESET;
    end else if (wr_edge && reg_sel) begin
      wr_shadow_q <= q.data_s2;
    end
  end

  AST_WRITE_READ: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (s_reg_read and !wr_edge) |=> io_data_oe_o &&
      io_data_o == $past(wr_shadow_q))
    else $error("register read does not return written value");

  AST_RESET_CLEAR: assert property (
    @(posedge clk_i)
    $rose(rst_n) |-> 16'(q.cfg) == rpcs_pkg::CFG_RESET && !cs_scsi_o &&
      !printer_port_bus_sel_o && !cas_hold_low_o)
    else $error("register not cleared by reset");

  AST_CAS_FIRST: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    s_reg_write ##2 1'b1
      |-> cas_first_refresh_enable_o == $past(q.data_s2[13], 2))
    else $error("CAS-first output does not follow its bit");

  AST_CAS_HOLD: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (q.cfg.cas_first_self_refresh && q.susp_s2)[*3] |=> cas_hold_low_o)
    else $error("CAS not held low in suspend");

  AST_SCSI_WINDOW: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    cs_scsi_o |-> $past(q.cfg.scsi_decode_enable) &&
      $past(q.addr_s2[15:4]) == 12'h353)
    else $error("SCSI select outside its window");

  AST_SCSI_PRESENT: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    ($past(q.cfg.scsi_decode_enable) && $past(q.addr_s2[15:4]) == 12'h353)
      |-> cs_scsi_o)
    else $error("SCSI select missing inside its window");

  AST_PRINTER_WINDOW: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    cs_printer_o |->
      ($past(q.cfg.printer_port_decode) == 2'h1 &&
       $past(q.addr_s2) >= 16'h03BC && $past(q.addr_s2) <= 16'h03BF) ||
      ($past(q.cfg.printer_port_decode) == 2'h2 &&
       $past(q.addr_s2) >= 16'h0378 && $past(q.addr_s2) <= 16'h037F) ||
      ($past(q.cfg.printer_port_decode) == 2'h3 &&
       $past(q.addr_s2) >= 16'h0278 && $past(q.addr_s2) <= 16'h027F))
    else $error("printer select outside its window");

  AST_FIRST_UART: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    ($past(q.cfg.first_uart_decode) == 3'h2 &&
     $past(q.addr_s2[15:3]) == 13'h005F) |-> cs_first_uart_o)
    else $error("first serial select missing in 2F8H window");

  AST_UART_OFF: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    ($past(q.cfg.second_uart_decode) == 3'h0 ||
     $past(q.cfg.second_uart_decode) > 3'h4) |-> !cs_second_uart_o)
    else $error("second serial select active while disabled");

  AST_SECOND_UART: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    cs_second_uart_o |-> $past(q.addr_s2[15:3]) ==
      ($past(q.cfg.second_uart_decode) == 3'h1 ? 13'h007F :
       $past(q.cfg.second_uart_decode) == 3'h2 ? 13'h005F :
       $past(q.cfg.second_uart_decode) == 3'h3 ? 13'h007D : 13'h005D))
    else $error("second serial select outside its window");

  AST_BUS_SEL: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    s_reg_write |=> printer_port_bus_sel_o == $past(q.data_s2[8]) &&
      first_uart_bus_sel_o == $past(q.data_s2[4]) &&
      second_uart_bus_sel_o == $past(q.data_s2[0]))
    else $error("bus placement does not follow written bits");

  AST_SELECT_LIVE: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (cs_first_uart_o && $changed(q.addr_s2[15:3]) &&
     $stable(q.cfg)) |=> !cs_first_uart_o)
    else $error("serial select held after address left window");

endmodule : rpcs_top

/* File: dv/rpcs_dram_model.sv */
// Far side model: low rate refresh tick source and DRAM refresh counter.
`timescale 1ns/1ps
module rpcs_dram_model #(
  parameter real TICK_PERIOD_NS = 15625.0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Refresh requests from the controller
  input wire logic main_refresh_req_i,
  input wire logic video_refresh_req_i,
  // Tick and refresh counts
  output logic low_rate_refresh_tick_o,
  output int main_count_o,
  output int video_count_o
);
  initial begin
    low_rate_refresh_tick_o = 1'b0;
    forever begin
      #(TICK_PERIOD_NS / 2.0);
      low_rate_refresh_tick_o = ~low_rate_refresh_tick_o;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_count_o <= 0;
      video_count_o <= 0;
    end else begin
      main_count_o <= main_count_o + int'(main_refresh_req_i);
      video_count_o <= video_count_o + int'(video_refresh_req_i);
    end
  end
endmodule : rpcs_dram_model

/* File: dv/tb_rpcs_top.sv */
// Self-checking testbench of the refresh and port chip select block.
`timescale 1ns/1ps
module tb_rpcs_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] io_addr_i = 16'h0000;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [15:0] io_data_i = 16'h0000;
  logic full_power_down_i = 1'b0;
  logic suspend_i = 1'b0;
  logic tick, main_req, video_req, cas_first, cas_hold;
  logic cs_scsi, cs_par, cs_ua, cs_ub, par_bus, ua_bus, ub_bus;
  logic [15:0] io_data_o;
  logic io_data_oe_o;
  int main_cnt, video_cnt, n_errors = 0, checks_done = 0, m0, v0;
  logic [15:0] pats[3] = '{16'hA5A5, 16'h5A5A, 16'h0111};
  logic [15:0] rcfg[3] = '{16'h0000, 16'h8000, 16'h4000};
  logic [15:0] par_base[3] = '{16'h03BC, 16'h0378, 16'h0278};
  logic [15:0] par_len[3] = '{16'h0004, 16'h0008, 16'h0008};
  logic [15:0] ua_base[4] = '{16'h03F8, 16'h02F8, 16'h03E8, 16'h02E8};
  logic [15:0] b;
  logic [3:0] e;
  logic [2:0] code;

  always #25 clk_i = ~clk_i;

  rpcs_top u_rpcs_top (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_data_i(io_data_i),
    .io_data_o(io_data_o), .io_data_oe_o(io_data_oe_o),
    .full_power_down_i(full_power_down_i), .suspend_i(suspend_i),
    .low_rate_refresh_tick_i(tick), .main_refresh_req_o(main_req),
    .video_refresh_req_o(video_req),
    .cas_first_refresh_enable_o(cas_first), .cas_hold_low_o(cas_hold),
    .cs_scsi_o(cs_scsi), .cs_printer_o(cs_par),
    .cs_first_uart_o(cs_ua), .cs_second_uart_o(cs_ub),
    .printer_port_bus_sel_o(par_bus), .first_uart_bus_sel_o(ua_bus),
    .second_uart_bus_sel_o(ub_bus)
  );

  rpcs_dram_model u_rpcs_dram_model (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .main_refresh_req_i(main_req),
    .video_refresh_req_i(video_req), .low_rate_refresh_tick_o(tick),
    .main_count_o(main_cnt), .video_count_o(video_cnt)
  );

  task automatic tally_and_finish();
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_up(input string what);
    n_errors++;
    $display("Error %s expected event seen none", what);
    tally_and_finish();
  endtask : give_up

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  // Address and data settle two cycles before the strobe, as the sync needs.
  task automatic reg_wr(input logic [15:0] d);
    io_addr_i = rpcs_pkg::REG_ADDR;
    io_data_i = d;
    cyc(2);
    io_wr_i = 1'b1;
    cyc(2);
    io_wr_i = 1'b0;
    cyc(3);
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp,
                        input logic oe);
    io_addr_i = a;
    cyc(2);
    io_rd_i = 1'b1;
    cyc(4);
    chk("read enable", {15'h0000, oe}, {15'h0000, io_data_oe_o});
    chk("read data", exp, io_data_o);
    io_rd_i = 1'b0;
    cyc(4);
    chk("read release", 16'h0000, {15'h0000, io_data_oe_o});
  endtask : reg_rd

  task automatic cs_at(input logic [15:0] a, input logic [3:0] exp);
    io_addr_i = a;
    cyc(4);
    chk("chip selects", {12'h000, exp},
        {12'h000, cs_scsi, cs_par, cs_ua, cs_ub});
  endtask : cs_at

  task automatic period(input logic vid, input int exp);
    int n;
    n = 0;
    while ((vid ? video_req : main_req) !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 3000) give_up("refresh pulse");
    end
    cyc(1);
    n = 1;
    while ((vid ? video_req : main_req) !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 3000) give_up("refresh pulse");
    end
    chk("refresh period", 16'(exp), 16'(n));
  endtask : period

  task automatic ticks(input int k);
    int t, n;
    logic prev;
    t = 0;
    n = 0;
    prev = tick;
    while (t < k) begin
      cyc(1);
      n++;
      if (tick === 1'b1 && prev === 1'b0) t++;
      prev = tick;
      if (n > 400 * k) give_up("refresh tick");
    end
  endtask : ticks

  initial begin
    cyc(5);
    rst_n_i = 1'b1;
    cyc(4);
    // ----------------------------------------------------------------
    // Reset state and register access
    // ----------------------------------------------------------------
    reg_rd(rpcs_pkg::REG_ADDR, 16'h0000, 1'b1);
    chk("bus and cas", 16'h0000,
        {11'h000, par_bus, ua_bus, ub_bus, cas_first, cas_hold});
    cs_at(16'h3530, 4'h0);
    cs_at(16'h0378, 4'h0);
    cs_at(16'h03F8, 4'h0);
    // No pattern gives both serial fields one window.
    for (int i = 0; i < 3; i++) begin
      reg_wr(pats[i]);
      reg_rd(rpcs_pkg::REG_ADDR, pats[i], 1'b1);
      chk("bus selects", {13'h0000, pats[i][8], pats[i][4], pats[i][0]},
          {13'h0000, par_bus, ua_bus, ub_bus});
    end
    reg_rd(16'h2073, 16'h0000, 1'b0);
    reg_rd(16'h2872, 16'h0000, 1'b0);
    // ----------------------------------------------------------------
    // Chip select windows and their edges
    // ----------------------------------------------------------------
    reg_wr(16'h0800);
    cs_at(16'h3530, 4'h8);
    cs_at(16'h353F, 4'h8);
    cs_at(16'h3540, 4'h0);
    cs_at(16'h352F, 4'h0);
    reg_wr(16'h0000);
    cs_at(16'h3535, 4'h0);
    for (int p = 0; p < 3; p++) begin
      reg_wr({5'h00, 2'(p + 1), 9'h000});
      b = par_base[p];
      cs_at(b, 4'h4);
      cs_at(b + par_len[p] - 16'h0001, 4'h4);
      cs_at(b + par_len[p], 4'h0);
      cs_at(b - 16'h0001, 4'h0);
    end
    for (int f = 0; f < 2; f++) begin
      for (int u = 0; u < 4; u++) begin
        code = 3'(u + 1);
        b = ua_base[u];
        e = (f == 0) ? 4'h2 : 4'h1;
        reg_wr((f == 0) ? {8'h00, code, 5'h00} :
               {12'h000, code, 1'b0});
        cs_at(b, e);
        cs_at(b + 16'h0007, e);
        cs_at(b + 16'h0008, 4'h0);
        cs_at(b - 16'h0001, 4'h0);
      end
    end
    // ----------------------------------------------------------------
    // CAS-first refresh and self refresh in suspend
    // ----------------------------------------------------------------
    reg_wr(16'h2000);
    chk("cas first", 16'h0001, {15'h0000, cas_first});
    suspend_i = 1'b1;
    cyc(4);
    chk("cas hold off", 16'h0000, {15'h0000, cas_hold});
    reg_wr(16'h1000);
    for (int i = 0; i < 8; i++) begin
      chk("cas hold", 16'h0001, {15'h0000, cas_hold});
      cyc(1);
    end
    chk("cas first off", 16'h0000, {15'h0000, cas_first});
    suspend_i = 1'b0;
    cyc(4);
    chk("cas hold end", 16'h0000, {15'h0000, cas_hold});
    // ----------------------------------------------------------------
    // Refresh pacing, running and in full power down
    // ----------------------------------------------------------------
    for (int i = 0; i < 3; i++) begin
      reg_wr(rcfg[i]);
      period(1'b0, rcfg[i][15] ? rpcs_pkg::REFRESH_CYC *
             rpcs_pkg::SLOW_FACTOR : rpcs_pkg::REFRESH_CYC);
      period(1'b1, rcfg[i][14] ? rpcs_pkg::REFRESH_CYC *
             rpcs_pkg::SLOW_FACTOR : rpcs_pkg::REFRESH_CYC);
    end
    full_power_down_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      reg_wr(rcfg[i]);
      ticks(2);
      cyc(8);
      m0 = main_cnt;
      v0 = video_cnt;
      ticks(16);
      cyc(8);
      chk("main per tick", rcfg[i][15] ? 16'h0002 : 16'h0010,
          16'(main_cnt - m0));
      chk("video per tick", rcfg[i][14] ? 16'h0002 : 16'h0010,
          16'(video_cnt - v0));
    end
    full_power_down_i = 1'b0;
    // ----------------------------------------------------------------
    // Reset in mid-run clears a written register
    // ----------------------------------------------------------------
    reg_wr(16'hA5A5);
    rst_n_i = 1'b0;
    cyc(2);
    rst_n_i = 1'b1;
    cyc(4);
    reg_rd(rpcs_pkg::REG_ADDR, 16'h0000, 1'b1);
    chk("bus after reset", 16'h0000,
        {13'h0000, par_bus, ua_bus, ub_bus});
    tally_and_finish();
  end
endmodule : tb_rpcs_top
